// File: inc/gphy_cfg.svh
`ifndef GPHY_CFG_SVH
`define GPHY_CFG_SVH

// port numbering and register indices (byte address is four times the index)
`define GPHY_NPORT 5
`define GPHY_PORT_FIRST 3'h1
`define GPHY_CTL_IDX 12'h112
`define GPHY_STS_IDX 12'h114
`define GPHY_IRQ_STAT_IDX 15'h0010
`define GPHY_IRQ_MASK_IDX 15'h0011

// control word fields
`define GPHY_TEST_HI 15
`define GPHY_TEST_LO 13
`define GPHY_MS_MAN_BIT 12
`define GPHY_MS_VAL_BIT 11
`define GPHY_PTYPE_BIT 10
`define GPHY_ADV_FD_BIT 9
`define GPHY_ADV_HD_BIT 8

// status word fields
`define GPHY_FAULT_BIT 15
`define GPHY_RESOLVED_BIT 14
`define GPHY_LRX_BIT 13
`define GPHY_RRX_BIT 12
`define GPHY_LP_FD_BIT 11
`define GPHY_LP_HD_BIT 10

// transmitter test codes
`define GPHY_TEST_NORMAL 3'h0
`define GPHY_TEST_LAST 3'h4

// reset values
`define GPHY_TEST_RST 3'h0
`define GPHY_MS_MAN_RST 1'h0
`define GPHY_MS_VAL_RST 1'h0
`define GPHY_PTYPE_RST 1'h1
`define GPHY_ADV_FD_RST 1'h1
`define GPHY_ADV_HD_RST 1'h1
`define GPHY_IDLE_CNT_RST 8'h00
`define GPHY_IDLE_CNT_MAX 8'hFF
`define GPHY_PAIRS_ON 4'hF
`define GPHY_PAIRS_OFF 4'h0

// interrupt status layout: faults in low bits, counter saturation above
`define GPHY_IRQ_SAT_LO 5

`endif

// File: inc/gphy_pkg.sv
package gphy_pkg;
	typedef logic [2:0] tx_test_t;
	typedef logic [7:0] idle_cnt_t;
	typedef logic [15:0] reg16_t;
	typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;
endpackage

// File: inc/port_bus_if.sv
`timescale 1ns/100ps
// register strobes between the bus slave and one port's register pair
interface port_bus_if;
	logic wr_ctl;
	logic rd_sts;
	logic [15:0] wdata;
	logic [1:0] be;
	logic [15:0] ctl;
	logic [15:0] sts;
	logic ev_fault;
	logic ev_sat;
	modport bus (output wr_ctl, rd_sts, wdata, be, input ctl, sts, ev_fault, ev_sat);
	modport port (input wr_ctl, rd_sts, wdata, be, output ctl, sts, ev_fault, ev_sat);
endinterface

// File: hw/gphy_port_regs.sv
`timescale 1ns/100ps
`include "gphy_cfg.svh"
module gphy_port_regs
	import gphy_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	port_bus_if.port bus,
	input wire logic i_forced_gig,
	input wire logic i_ms_fault,
	input wire logic i_resolved_master,
	input wire logic i_local_rx_ok,
	input wire logic i_remote_rx_ok,
	input wire logic i_lp_adv_fd,
	input wire logic i_lp_adv_hd,
	input wire logic i_rx_idle,
	input wire logic i_tx_send_n,
	input wire logic i_rx_error,
	output logic [2:0] o_test_mode,
	output logic [3:0] o_pair_drive,
	output logic o_ms_force_en,
	output logic o_ms_force_master,
	output logic o_prefer_master,
	output logic o_adv_fd,
	output logic o_adv_hd
);

	tx_test_t test_mode;
	logic ms_manual;
	logic ms_value;
	logic port_type;
	logic adv_fd;
	logic adv_hd;
	logic fault;
	idle_cnt_t idle_cnt;
	wire idle_hit;
	wire test_valid;
	wire cnt_full;

	////////////////////////////////////////////////////////////////////////
	// control word: upper byte lane holds every writable field
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			test_mode <= `GPHY_TEST_RST;
			ms_manual <= `GPHY_MS_MAN_RST;
			ms_value <= `GPHY_MS_VAL_RST;
			port_type <= `GPHY_PTYPE_RST;
			adv_fd <= `GPHY_ADV_FD_RST;
			adv_hd <= `GPHY_ADV_HD_RST;
		end
		else if (bus.wr_ctl && bus.be[1])
		begin
			test_mode <= bus.wdata[`GPHY_TEST_HI:`GPHY_TEST_LO];
			ms_manual <= bus.wdata[`GPHY_MS_MAN_BIT];
			ms_value <= bus.wdata[`GPHY_MS_VAL_BIT];
			port_type <= bus.wdata[`GPHY_PTYPE_BIT];
			adv_fd <= bus.wdata[`GPHY_ADV_FD_BIT];
			adv_hd <= bus.wdata[`GPHY_ADV_HD_BIT];
		end
	end

	// reserved codes 101..111 are stored and passed to o_test_mode but drive no pairs
	assign test_valid = (test_mode != `GPHY_TEST_NORMAL) && (test_mode <= `GPHY_TEST_LAST);
	assign idle_hit = i_rx_idle && i_tx_send_n && i_rx_error;
	assign cnt_full = (idle_cnt == `GPHY_IDLE_CNT_MAX);

	////////////////////////////////////////////////////////////////////////
	// role and advertisement outputs; value and preference gated by enable
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_test_mode <= `GPHY_TEST_RST;
			o_pair_drive <= `GPHY_PAIRS_OFF;
			o_ms_force_en <= 1'h0;
			o_ms_force_master <= 1'h0;
			o_prefer_master <= 1'h0;
			o_adv_fd <= 1'h0;
			o_adv_hd <= 1'h0;
		end
		else
		begin
			o_test_mode <= test_mode;
			// all four pairs, no partner needed, only after speed is forced
			o_pair_drive <= (test_valid && i_forced_gig) ? `GPHY_PAIRS_ON : `GPHY_PAIRS_OFF;
			o_ms_force_en <= ms_manual;
			o_ms_force_master <= ms_manual && ms_value;
			o_prefer_master <= !ms_manual && port_type;
			o_adv_fd <= adv_fd;
			o_adv_hd <= adv_hd;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sticky fault and idle error count; a new event beats the read clear
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			fault <= 1'h0;
			idle_cnt <= `GPHY_IDLE_CNT_RST;
		end
		else
		begin
			fault <= i_ms_fault || (fault && !bus.rd_sts);
			if (bus.rd_sts)
				idle_cnt <= idle_hit ? 8'h01 : `GPHY_IDLE_CNT_RST;
			else if (idle_hit && !cnt_full)
				idle_cnt <= idle_cnt + 8'h01;
		end
	end

	assign bus.ev_fault = i_ms_fault;
	assign bus.ev_sat = idle_hit && (idle_cnt == 8'hFE) && !bus.rd_sts;
	assign bus.ctl = {test_mode, ms_manual, ms_value, port_type, adv_fd, adv_hd, 8'h00};
	// reserved pair 9:8 reads 00
	assign bus.sts = {fault, i_resolved_master, i_local_rx_ok, i_remote_rx_ok,
		i_lp_adv_fd, i_lp_adv_hd, 2'h0, idle_cnt};

endmodule

// File: hw/gphy_regs_top.sv
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "gphy_cfg.svh"

//////////////////////////////////////////////////////////////////////////////
// gigabit control and status register bank for five PHY ports, reached over
// a classic Wishbone slave with 32-bit data; 16-bit registers sit in the low
// half of each word, upper bits read zero.
//////////////////////////////////////////////////////////////////////////////

// Contract
// - one control and status pair per port 1-5
// - three-bit test field selects transmitter test
// - test waveform on all four pairs
// - enable bit selects manual role, resets 0
// - value bit forces master/slave when manual
// - port type gives role preference, resets 1
// - advertise gigabit full duplex, resets 1
// - advertise gigabit half duplex, resets 1
// - sticky role fault, cleared on read
// - resolution bit shows master or slave
// - local and remote receiver OK bits
// - partner gigabit abilities; reserved bits zero
// - idle error counter, qualified, clears on read
module gphy_regs_top
	import gphy_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [16:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	output logic o_irq,
	input wire logic [4:0] i_forced_gig,
	input wire logic [4:0] i_ms_fault,
	input wire logic [4:0] i_resolved_master,
	input wire logic [4:0] i_local_rx_ok,
	input wire logic [4:0] i_remote_rx_ok,
	input wire logic [4:0] i_lp_adv_fd,
	input wire logic [4:0] i_lp_adv_hd,
	input wire logic [4:0] i_rx_idle,
	input wire logic [4:0] i_tx_send_n,
	input wire logic [4:0] i_rx_error,
	output logic [14:0] o_test_mode,
	output logic [19:0] o_pair_drive,
	output logic [4:0] o_ms_force_en,
	output logic [4:0] o_ms_force_master,
	output logic [4:0] o_prefer_master,
	output logic [4:0] o_adv_fd,
	output logic [4:0] o_adv_hd
);

	localparam int NPORT = `GPHY_NPORT;

	bus_state_t bus_state;
	bus_state_t next_bus_state;
	logic [9:0] irq_stat;
	logic [9:0] irq_mask;
	logic [9:0] next_irq_stat;

	wire [14:0] reg_idx;
	wire [2:0] port_digit;
	wire [11:0] port_off;
	wire req_new;
	wire req_commit;
	wire rd_take;
	wire wr_take;
	wire hit_irq_stat;
	wire hit_irq_mask;
	wire [NPORT-1:0] hit_ctl;
	wire [NPORT-1:0] hit_sts;
	wire [NPORT-1:0] ev_fault;
	wire [NPORT-1:0] ev_sat;
	wire [9:0] irq_events;
	wire [15:0] port_rdata [NPORT];
	wire [15:0] irq_rdata;
	logic [15:0] sel_rdata;

	//////////////////////////////////////////////////////////////////////////
	// address decode: printed offsets are word indices, so byte address
	// bits 1:0 are dropped and the port number is the top index digit
	assign reg_idx = i_wb_adr[16:2];
	assign port_digit = reg_idx[14:12];
	assign port_off = reg_idx[11:0];
	assign hit_irq_stat = (reg_idx == `GPHY_IRQ_STAT_IDX);
	assign hit_irq_mask = (reg_idx == `GPHY_IRQ_MASK_IDX);

	//////////////////////////////////////////////////////////////////////////
	// bus handshake: a request is seen in BUS_IDLE, acked one cycle later.
	// reads sample and clear at the first edge so no count slips between
	// the captured value and the clear; writes land on the ack edge.
	assign req_new = i_wb_cyc && i_wb_stb && (bus_state == BUS_IDLE);
	assign req_commit = i_wb_cyc && i_wb_stb && (bus_state == BUS_ACK);
	assign rd_take = req_new && !i_wb_we;
	assign wr_take = req_commit && i_wb_we;

	always_comb
	begin
		next_bus_state = bus_state;
		case (bus_state)
			BUS_IDLE:
				if (i_wb_cyc && i_wb_stb)
					next_bus_state = BUS_ACK;
			BUS_ACK:
				next_bus_state = BUS_IDLE;
			default:
				next_bus_state = BUS_IDLE;
		endcase
	end

	// state register and ack; ack is high exactly while in BUS_ACK
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			bus_state <= BUS_IDLE;
			o_wb_ack <= 1'h0;
		end
		else
		begin
			bus_state <= next_bus_state;
			o_wb_ack <= (next_bus_state == BUS_ACK);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// one register pair per port; the loop index p serves port p+1
	genvar p;
	generate
		for (p = 0; p < NPORT; p++)
		begin : g_port
			port_bus_if pbus();

			assign hit_ctl[p] = (port_digit == 3'(p + 1)) && (port_off == `GPHY_CTL_IDX);
			assign hit_sts[p] = (port_digit == 3'(p + 1)) && (port_off == `GPHY_STS_IDX);
			assign pbus.wr_ctl = wr_take && hit_ctl[p];
			assign pbus.rd_sts = rd_take && hit_sts[p];
			assign pbus.wdata = i_wb_dat[15:0];
			assign pbus.be = i_wb_sel[1:0];
			assign ev_fault[p] = pbus.ev_fault;
			assign ev_sat[p] = pbus.ev_sat;
			assign port_rdata[p] = hit_ctl[p] ? pbus.ctl : (hit_sts[p] ? pbus.sts : 16'h0000);

			gphy_port_regs u_port (
				.i_sys_clk(i_sys_clk),
				.i_rst_n(i_rst_n),
				.bus(pbus),
				.i_forced_gig(i_forced_gig[p]),
				.i_ms_fault(i_ms_fault[p]),
				.i_resolved_master(i_resolved_master[p]),
				.i_local_rx_ok(i_local_rx_ok[p]),
				.i_remote_rx_ok(i_remote_rx_ok[p]),
				.i_lp_adv_fd(i_lp_adv_fd[p]),
				.i_lp_adv_hd(i_lp_adv_hd[p]),
				.i_rx_idle(i_rx_idle[p]),
				.i_tx_send_n(i_tx_send_n[p]),
				.i_rx_error(i_rx_error[p]),
				.o_test_mode(o_test_mode[3*p +: 3]),
				.o_pair_drive(o_pair_drive[4*p +: 4]),
				.o_ms_force_en(o_ms_force_en[p]),
				.o_ms_force_master(o_ms_force_master[p]),
				.o_prefer_master(o_prefer_master[p]),
				.o_adv_fd(o_adv_fd[p]),
				.o_adv_hd(o_adv_hd[p])
			);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// interrupt status: faults in 4:0, counter saturation in 9:5.
	// write one to clear; an event in the clearing cycle still sets
	assign irq_events = {ev_sat, ev_fault};
	assign irq_rdata = hit_irq_stat ? {6'h00, irq_stat} :
		(hit_irq_mask ? {6'h00, irq_mask} : 16'h0000);

	always_comb
	begin
		next_irq_stat = irq_stat;
		if (wr_take && hit_irq_stat)
		begin
			if (i_wb_sel[0])
				next_irq_stat[7:0] = irq_stat[7:0] & ~i_wb_dat[7:0];
			if (i_wb_sel[1])
				next_irq_stat[9:8] = irq_stat[9:8] & ~i_wb_dat[9:8];
		end
		next_irq_stat = next_irq_stat | irq_events;
	end

	// status, mask and the level interrupt, all registered
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			irq_stat <= 10'h000;
			irq_mask <= 10'h000;
			o_irq <= 1'h0;
		end
		else
		begin
			irq_stat <= next_irq_stat;
			if (wr_take && hit_irq_mask && i_wb_sel[0])
				irq_mask[7:0] <= i_wb_dat[7:0];
			if (wr_take && hit_irq_mask && i_wb_sel[1])
				irq_mask[9:8] <= i_wb_dat[9:8];
			// one cycle behind both the status bit and the mask register
			o_irq <= |(irq_stat & irq_mask);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// read data: at most one source decodes, so an OR of the ports is safe;
	// unmapped addresses answer with ack and zero data
	always_comb
	begin
		sel_rdata = irq_rdata;
		for (int k = 0; k < NPORT; k++)
			sel_rdata = sel_rdata | port_rdata[k];
	end

	// captured on the request edge and held through the ack cycle
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_wb_dat <= 32'h00000000;
		else if (rd_take)
			o_wb_dat <= {16'h0000, sel_rdata};
	end

endmodule

// File: testbench/gphy_regs_assertions.sv
`timescale 1ns/100ps
// watches port 1, the role outputs of all five ports and the bus; every assertion checks a design output
module gphy_regs_assertions
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [16:0] i_wb_adr,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	input wire logic [4:0] i_forced_gig,
	input wire logic [4:0] i_resolved_master,
	input wire logic [4:0] i_local_rx_ok,
	input wire logic [4:0] i_remote_rx_ok,
	input wire logic [4:0] i_lp_adv_fd,
	input wire logic [4:0] i_lp_adv_hd,
	input wire logic [14:0] o_test_mode,
	input wire logic [19:0] o_pair_drive,
	input wire logic [4:0] o_ms_force_en,
	input wire logic [4:0] o_ms_force_master,
	input wire logic [4:0] o_prefer_master
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);
	wire req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	// a read request to one address, then its answer
	sequence rd_of(logic [16:0] a);
		req && !i_wb_we && i_wb_adr == a ##1 o_wb_ack;
	endsequence
	ack_follows_a: assert property (req |=> o_wb_ack)
		else $error("request not answered in one cycle");
	ack_single_a: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property ($rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb))
		else $error("ack without request");
	upper_zero_a: assert property (o_wb_ack |-> o_wb_dat[31:16] == 16'h0000)
		else $error("upper read data not zero");
	ctl_rsvd_a: assert property (rd_of(17'h04448) |-> o_wb_dat[7:0] == 8'h00)
		else $error("control low byte not zero");
	live_bits_a: assert property (rd_of(17'h04450) |-> o_wb_dat[14:8] == $past({
		i_resolved_master[0], i_local_rx_ok[0], i_remote_rx_ok[0],
		i_lp_adv_fd[0], i_lp_adv_hd[0], 2'b00}))
		else $error("status live bits wrong");
	// drive only for a defined test code and only once 1000 Mbps is forced
	pair_drive_a: assert property (o_pair_drive[3:0] == ((o_test_mode[2:0] inside
		{[3'h1:3'h4]} && $past(i_forced_gig[0])) ? 4'hF : 4'h0))
		else $error("pair drive disagrees with test mode");
	force_master_a: assert property ((o_ms_force_master & ~o_ms_force_en) == 5'h00)
		else $error("role value used while manual is off");
	prefer_gated_a: assert property ((o_prefer_master & o_ms_force_en) == 5'h00)
		else $error("port type used while manual is on");
endmodule
bind gphy_regs_top gphy_regs_assertions chk (.*);

// File: testbench/link_partner.sv
`timescale 1ns/100ps
// far-end PHY: role, receiver health, abilities and idle error qualifiers
module link_partner
(
	input wire logic [4:0] i_pat,
	input wire logic [4:0] i_err,
	input wire logic i_idle,
	input wire logic i_send,
	output logic [4:0] o_master,
	output logic [4:0] o_lrx,
	output logic [4:0] o_rrx,
	output logic [4:0] o_fd,
	output logic [4:0] o_hd,
	output logic [4:0] o_idle,
	output logic [4:0] o_send_n,
	output logic [4:0] o_err
);
	// neighbours alternate so a swapped status bit cannot read right
	assign o_master = i_pat;
	assign o_lrx = ~i_pat;
	assign o_rrx = i_pat;
	assign o_fd = ~i_pat;
	assign o_hd = i_pat;
	// idle and send mode come apart so each qualifier is tested alone
	assign o_idle = {5{i_idle}};
	assign o_send_n = {5{i_send}};
	assign o_err = i_err;
endmodule

// File: testbench/gphy_regs_top_tb.sv
`timescale 1ns/100ps
module gphy_regs_top_tb;
	import gphy_pkg::*;
	logic i_sys_clk, i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, o_irq, idle, send;
	logic [16:0] i_wb_adr;
	logic [3:0] i_wb_sel;
	logic [3:0] wsel;
	logic [31:0] i_wb_dat, o_wb_dat, q;
	logic [4:0] i_forced_gig, i_ms_fault, i_resolved_master, i_local_rx_ok;
	logic [4:0] i_remote_rx_ok, i_lp_adv_fd, i_lp_adv_hd, i_rx_idle, i_tx_send_n;
	logic [4:0] i_rx_error, pat, err, o_ms_force_en, o_ms_force_master;
	logic [4:0] o_prefer_master, o_adv_fd, o_adv_hd;
	logic [14:0] o_test_mode;
	logic [19:0] o_pair_drive;
	logic [15:0] rv [4] = '{16'h1B00, 16'h1400, 16'h0B00, 16'h0400};
	logic [19:0] ro [4] = '{20'h10BBF, 20'h103BD, 20'h003BF, 20'h003FD};
	int error_cnt = 0;
	int comparisons = 0;
	gphy_regs_top dut (.*);
	link_partner lp (.i_pat(pat), .i_err(err), .i_idle(idle), .o_master(i_resolved_master),
		.i_send(send), .o_lrx(i_local_rx_ok), .o_rrx(i_remote_rx_ok), .o_fd(i_lp_adv_fd),
		.o_hd(i_lp_adv_hd), .o_idle(i_rx_idle), .o_send_n(i_tx_send_n), .o_err(i_rx_error));
	always #4 i_sys_clk = ~i_sys_clk;
	//////////////////////////////////////////////////////////////////////////////
	task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected read at %0t: %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic check_pin(input logic [19:0] got, input logic [19:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected pins at %0t: %h, wanted %h", $time, got, exp);
		end
	endtask
	// one classic cycle; a dead slave is left to the watchdog
	task automatic wb(input logic w, input logic [16:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= w;
		i_wb_adr <= a;
		i_wb_dat <= d;
		i_wb_sel <= wsel;
		do
			@(posedge i_sys_clk);
		while (o_wb_ack !== 1'b1);
		q = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
	endtask
	task automatic rd(input logic [16:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		check_reg(q, e);
	endtask
	// outputs follow a write two edges after its ack
	task automatic settle;
		repeat (2) @(negedge i_sys_clk);
	endtask
	// starts on a rising edge so exactly n edges see the error
	task automatic burst(input logic i, input logic s, input int n);
		@(posedge i_sys_clk);
		idle <= i;
		send <= s;
		err <= 5'h01;
		repeat (n) @(posedge i_sys_clk);
		err <= 5'h00;
		idle <= 1'b0;
		send <= 1'b0;
	endtask
	function automatic logic [16:0] ra(input int p, input logic s);
		return {p[2:0], 14'h0448} + (s ? 17'h00008 : 17'h00000);
	endfunction
	function automatic logic [31:0] exp_sts(input int p, input logic f, input logic [7:0] c);
		logic b;
		b = pat[p - 1];
		return {16'h0000, f, b, ~b, b, ~b, b, 2'b00, c};
	endfunction
	task automatic print_verdict;
		$display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#100000;
		error_cnt++;
		print_verdict;
	end
	initial
	begin
		{i_sys_clk, i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we, idle, send} = 7'h00;
		{i_wb_adr, i_wb_dat, i_forced_gig, i_ms_fault, err} = 64'h0;
		i_wb_sel = 4'hF;
		wsel = 4'hF;
		pat = 5'h0A;
		repeat (2) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		for (int p = 1; p <= 5; p++)
		begin
			rd(ra(p, 1'b0), 32'h00000700);
			rd(ra(p, 1'b1), exp_sts(p, 1'b0, 8'h00));
		end
		check_pin({o_prefer_master, o_adv_fd, o_adv_hd, o_ms_force_en}, 20'hFFFE0);
		wb(1'b1, ra(6, 1'b0), 32'h0000E000);
		rd(ra(6, 1'b0), 32'h0);
		rd(ra(0, 1'b0), 32'h0);
		i_forced_gig <= 5'h01;
		for (int c = 0; c < 8; c++)
		begin
			wb(1'b1, ra(1, 1'b0), {16'h0, c[2:0], 13'h0700});
			settle;
			check_pin({o_test_mode[2:0], 13'h0, o_pair_drive[3:0]},
				{c[2:0], 13'h0, (c >= 1 && c <= 4) ? 4'hF : 4'h0});
			rd(ra(1, 1'b0), {16'h0, c[2:0], 13'h0700});
		end
		// a test code without 1000 Mbps forced must stay quiet
		i_forced_gig <= 5'h00;
		wb(1'b1, ra(1, 1'b0), 32'h00002700);
		settle;
		check_pin({16'h0, o_pair_drive[3:0]}, 20'h0);
		for (int i = 0; i < 4; i++)
		begin
			wb(1'b1, ra(2, 1'b0), {16'h0, rv[i]});
			settle;
			check_pin({o_ms_force_en, o_ms_force_master, o_prefer_master, o_adv_fd}, ro[i]);
			check_pin({15'h0, o_adv_hd}, {15'h0, ro[i][4:0]});
		end
		// fault on port 2, masked in, cleared by reading
		wb(1'b1, 17'h00044, 32'h2);
		i_ms_fault <= 5'h02;
		@(posedge i_sys_clk);
		i_ms_fault <= 5'h00;
		settle;
		check_pin({19'h0, o_irq}, 20'h1);
		rd(ra(2, 1'b1), exp_sts(2, 1'b1, 8'h00));
		rd(ra(2, 1'b1), exp_sts(2, 1'b0, 8'h00));
		wb(1'b1, 17'h00040, 32'h2);
		settle;
		check_pin({19'h0, o_irq}, 20'h0);
		// errors outside idles, or outside send mode, are not counted
		burst(1'b0, 1'b1, 4);
		rd(ra(1, 1'b1), exp_sts(1, 1'b0, 8'h00));
		burst(1'b1, 1'b0, 4);
		rd(ra(1, 1'b1), exp_sts(1, 1'b0, 8'h00));
		burst(1'b1, 1'b1, 3);
		rd(ra(1, 1'b1), exp_sts(1, 1'b0, 8'h03));
		rd(ra(1, 1'b1), exp_sts(1, 1'b0, 8'h00));
		burst(1'b1, 1'b1, 300);
		rd(ra(1, 1'b1), exp_sts(1, 1'b0, 8'hFF));
		rd(17'h00040, 32'h00000020);
		// saturation is masked out here, so the interrupt line stays low
		check_pin({19'h0, o_irq}, 20'h0);
		// a control write on the low byte lane alone changes nothing
		wsel = 4'h1;
		wb(1'b1, ra(3, 1'b0), 32'h0000E000);
		wsel = 4'hF;
		rd(ra(3, 1'b0), 32'h00000700);
		print_verdict;
	end
endmodule
